/* File: lcd_parser_regs.vh */
// Register map, reset values and command codes of the serial display command parser
`ifndef LCD_PARSER_REGS_VH
`define LCD_PARSER_REGS_VH

// Register byte offsets
`define OFS_DRAW_MODE      8'h00
`define OFS_STATUS         8'h04
`define OFS_NV_A           8'h08
`define OFS_NV_B           8'h0C

// Field positions of the persistent settings
`define NVA_BAUD_LSB       0
`define NVA_SPLASH_LSB     4
`define NVA_LINE_END_BIT   8
`define NVA_REVERSE_BIT    9
`define NVA_BACKLIGHT_LSB  16
`define NVB_SCROLL_LSB     0
`define NVB_RESUME_LSB     8
`define NVB_PAUSE_LSB      16
`define NVB_FONT_BIT       24

// Factory default values
`define DEF_BAUD_CODE      3'h6
`define DEF_SPLASH         2'h1
`define DEF_LINE_END       1'b0
`define DEF_REVERSE        1'b0
`define DEF_BACKLIGHT      8'h64
`define DEF_SCROLL         8'h00
`define DEF_RESUME         8'h14
`define DEF_PAUSE          8'hA6
`define DEF_FONT           1'b0
`define DEF_DRAW_MODE      8'h01
`define DEF_TEXT_MODE      8'h01

// Stream bytes and command codes
`define CMD_LEADER         8'h7C
`define CMD_ECHO           8'h17
`define CMD_ERASE          8'h05
`define CMD_RESTORE        8'h1F
`define CMD_PFILL          8'h06
`define CMD_MFILL          8'h46
`define CMD_TEXT_MODE      8'h0A
`define CMD_FONT_PERSIST   8'h08
`define CMD_FONT_TEMP      8'h48
`define CMD_BATCH_ENTER    8'h40
`define CMD_BATCH_EXIT     8'h41

// Mode byte fields
`define MODE_NORMAL_BIT    0
`define MODE_LOGIC_LSB     1
`define MODE_FILL_BIT      3
`define MODE_PROP_BIT      5

// Drawing operations handed to the renderer
`define OP_TEXT            2'h0
`define OP_ERASE           2'h1
`define OP_PFILL           2'h2
`define OP_MFILL           2'h3

`endif

/* File: lcd_cmd_parser.v */
// Byte-stream command interpreter for a serial graphic display, with APB settings access
// Operation
// - Outside batch mode each command is leader byte, code, then parameters.
// - Echo command sends its parameter byte back on the serial output.
// - Echo waits until all earlier drawing work has finished.
// - Erase takes two corners and clears the rectangle honouring reverse.
// - Rectangles include both corner coordinates.
// - Restore defaults overwrites every persistent setting.
// - Defaults: 115200, info splash, line end 0, normal, 100%, 0, 20, 166.
// - Pattern fill uses a pattern byte; mode fill takes no pattern.
// - Pattern byte is an eight-row vertical stripe repeated everywhere.
// - Fill without pattern takes colour and fill from draw mode.
// - Text mode command sets text rendering mode, decoded like draw mode.
// - Proportional flag in text mode renders fixed font proportionally.
// - Font zero is the 6x8 font, font one the 4x6 font.
// - Persistent font code also stores default; temporary code does not.
// - Batch mode takes codes without leader byte.
// - Batch mode ends on exit code or a leader-prefixed command.
// - Mode byte: bit0 normal, field 2/4/6 OR/XOR/NAND, bit3 fill.
//
// Design decisions made here: register access over APB and the register addresses.
`include "lcd_parser_regs.vh"

module lcd_cmd_parser (
  input  wire        i_clk,
  input  wire        i_rst_b,
  input  wire        i_psel,
  input  wire        i_penable,
  input  wire        i_pwrite,
  input  wire [7:0]  i_paddr,
  input  wire [31:0] i_pwdata,
  output reg  [31:0] o_prdata,
  output wire        o_pready,
  output wire        o_pslverr,
  input  wire        i_rx_valid,
  input  wire [7:0]  i_rx_data,
  output wire        o_rx_ready,
  output wire        o_draw_valid,
  output reg  [1:0]  o_draw_op,
  output reg  [7:0]  o_draw_x1,
  output reg  [7:0]  o_draw_y1,
  output reg  [7:0]  o_draw_x2,
  output reg  [7:0]  o_draw_y2,
  output reg  [7:0]  o_draw_data,
  input  wire        i_draw_ready,
  input  wire        i_draw_busy,
  output wire        o_tx_valid,
  output reg  [7:0]  o_tx_data,
  input  wire        i_tx_ready,
  output wire        o_font_sel,
  output wire [7:0]  o_text_mode,
  output wire        o_text_normal,
  output wire [1:0]  o_text_logic,
  output wire        o_text_fill,
  output wire        o_text_prop,
  output wire        o_draw_normal,
  output wire [1:0]  o_draw_logic,
  output wire        o_draw_fill
);

  localparam [2:0] ST_IDLE  = 3'd0;
  localparam [2:0] ST_CODE  = 3'd1;
  localparam [2:0] ST_PARAM = 3'd2;
  localparam [2:0] ST_EXEC  = 3'd3;
  localparam [2:0] ST_DRAW  = 3'd4;
  localparam [2:0] ST_ECHO  = 3'd5;

  reg [2:0]  state_reg;
  reg [7:0]  code_reg;
  reg [2:0]  cnt_reg;
  reg [7:0]  par_reg [0:4];
  reg        batch_reg;
  reg        font_reg;
  reg [7:0]  draw_mode_reg;
  reg [7:0]  text_mode_reg;
  reg [31:0] nva_reg;
  reg [31:0] nvb_reg;
  reg        restore_pulse;

  // Parameter bytes that follow each code; unknown codes take none
  // pattern fill always takes its pattern byte
  function [2:0] param_count;
    input [7:0] code;
    begin
      case (code)
        `CMD_ECHO:         param_count = 3'd1;
        `CMD_ERASE:        param_count = 3'd4;
        `CMD_PFILL:        param_count = 3'd5;
        `CMD_MFILL:        param_count = 3'd4;
        `CMD_TEXT_MODE:    param_count = 3'd1;
        `CMD_FONT_PERSIST: param_count = 3'd1;
        `CMD_FONT_TEMP:    param_count = 3'd1;
        default:           param_count = 3'd0;
      endcase
    end
  endfunction

  // Logic field of a mode byte: 0 plain, 1 OR, 2 XOR, 3 NAND
  function [1:0] mode_logic;
    input [7:0] mode;
    begin
      mode_logic = mode[`MODE_LOGIC_LSB+1:`MODE_LOGIC_LSB];
    end
  endfunction

  wire rx_take = i_rx_valid && o_rx_ready;
  wire [2:0] rx_count = param_count(i_rx_data);

  assign o_rx_ready   = (state_reg == ST_IDLE) || (state_reg == ST_CODE) ||
                        (state_reg == ST_PARAM);
  assign o_draw_valid = (state_reg == ST_DRAW);
  // Echo leaves only once the renderer has drained earlier work
  // echo after drawing
  assign o_tx_valid   = (state_reg == ST_ECHO) && !i_draw_busy;

  assign o_font_sel    = font_reg;
  assign o_text_mode   = text_mode_reg;
  assign o_text_normal = text_mode_reg[`MODE_NORMAL_BIT];
  assign o_text_logic  = mode_logic(text_mode_reg);
  assign o_text_fill   = text_mode_reg[`MODE_FILL_BIT];
  assign o_text_prop   = text_mode_reg[`MODE_PROP_BIT];
  assign o_draw_normal = draw_mode_reg[`MODE_NORMAL_BIT];
  assign o_draw_logic  = mode_logic(draw_mode_reg);
  assign o_draw_fill   = draw_mode_reg[`MODE_FILL_BIT];

  // Corners sorted so the renderer always walks low to high, both ends included
  wire [7:0] ax = par_reg[0];
  wire [7:0] ay = par_reg[1];
  wire [7:0] bx = par_reg[2];
  wire [7:0] by = par_reg[3];

  // Byte parser and command execution
  always @(posedge i_clk) begin
    if (!i_rst_b) begin
      state_reg     <= ST_IDLE;
      code_reg      <= 8'h00;
      cnt_reg       <= 3'd0;
      batch_reg     <= 1'b0;
      font_reg      <= `DEF_FONT;
      text_mode_reg <= `DEF_TEXT_MODE;
      restore_pulse <= 1'b0;
      o_draw_op     <= `OP_TEXT;
      o_draw_x1     <= 8'h00;
      o_draw_y1     <= 8'h00;
      o_draw_x2     <= 8'h00;
      o_draw_y2     <= 8'h00;
      o_draw_data   <= 8'h00;
      o_tx_data     <= 8'h00;
    end else begin
      restore_pulse <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          if (rx_take) begin
            if (i_rx_data == `CMD_LEADER) begin
              batch_reg <= 1'b0;
              state_reg <= ST_CODE;
            end else if (batch_reg) begin
              code_reg  <= i_rx_data;
              cnt_reg   <= 3'd0;
              state_reg <= (rx_count == 3'd0) ? ST_EXEC : ST_PARAM;
            end else begin
              o_draw_op   <= `OP_TEXT;
              o_draw_data <= i_rx_data;
              state_reg   <= ST_DRAW;
            end
          end
        end
        ST_CODE: begin
          if (rx_take) begin
            code_reg  <= i_rx_data;
            cnt_reg   <= 3'd0;
            state_reg <= (rx_count == 3'd0) ? ST_EXEC : ST_PARAM;
          end
        end
        ST_PARAM: begin
          if (rx_take) begin
            par_reg[cnt_reg] <= i_rx_data;
            cnt_reg          <= cnt_reg + 3'd1;
            if (cnt_reg + 3'd1 == param_count(code_reg)) begin
              state_reg <= ST_EXEC;
            end
          end
        end
        ST_EXEC: begin
          o_draw_x1 <= (ax < bx) ? ax : bx;
          o_draw_x2 <= (ax < bx) ? bx : ax;
          o_draw_y1 <= (ay < by) ? ay : by;
          o_draw_y2 <= (ay < by) ? by : ay;
          state_reg <= ST_IDLE;
          case (code_reg)
            `CMD_ECHO: begin
              o_tx_data <= par_reg[0];
              state_reg <= ST_ECHO;
            end
            `CMD_ERASE: begin
              o_draw_op   <= `OP_ERASE;
              o_draw_data <= nva_reg[`NVA_REVERSE_BIT] ? 8'hFF : 8'h00;
              state_reg   <= ST_DRAW;
            end
            `CMD_PFILL: begin
              o_draw_op   <= `OP_PFILL;
              o_draw_data <= par_reg[4];
              state_reg   <= ST_DRAW;
            end
            `CMD_MFILL: begin
              o_draw_op   <= `OP_MFILL;
              o_draw_data <= draw_mode_reg;
              state_reg   <= ST_DRAW;
            end
            `CMD_TEXT_MODE: begin
              text_mode_reg <= par_reg[0];
            end
            `CMD_FONT_PERSIST, `CMD_FONT_TEMP: begin
              font_reg <= par_reg[0][0];
            end
            `CMD_RESTORE: begin
              restore_pulse <= 1'b1;
            end
            `CMD_BATCH_ENTER: begin
              batch_reg <= 1'b1;
            end
            `CMD_BATCH_EXIT: begin
              batch_reg <= 1'b0;
            end
            default: begin
              state_reg <= ST_IDLE;
            end
          endcase
        end
        ST_DRAW: begin
          if (i_draw_ready) begin
            state_reg <= ST_IDLE;
          end
        end
        ST_ECHO: begin
          if (o_tx_valid && i_tx_ready) begin
            state_reg <= ST_IDLE;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // APB decode; zero wait states, unmapped offsets answer with an error
  wire apb_setup  = i_psel && !i_penable;
  wire apb_access = i_psel && i_penable;
  wire addr_hit   = (i_paddr == `OFS_DRAW_MODE) || (i_paddr == `OFS_STATUS) ||
                    (i_paddr == `OFS_NV_A) || (i_paddr == `OFS_NV_B);
  wire apb_wr     = apb_access && i_pwrite;
  wire font_store = (state_reg == ST_EXEC) && (code_reg == `CMD_FONT_PERSIST);

  assign o_pready  = 1'b1;
  assign o_pslverr = apb_access && !addr_hit;

  // Persistent settings and default draw mode; a command beats a same-cycle bus write
  always @(posedge i_clk) begin
    if (!i_rst_b) begin
      draw_mode_reg <= `DEF_DRAW_MODE;
      nva_reg       <= 32'h0000_0000;
      nvb_reg       <= 32'h0000_0000;
      nva_reg[`NVA_BAUD_LSB+2:`NVA_BAUD_LSB]           <= `DEF_BAUD_CODE;
      nva_reg[`NVA_SPLASH_LSB+1:`NVA_SPLASH_LSB]       <= `DEF_SPLASH;
      nva_reg[`NVA_BACKLIGHT_LSB+7:`NVA_BACKLIGHT_LSB] <= `DEF_BACKLIGHT;
      nvb_reg[`NVB_RESUME_LSB+7:`NVB_RESUME_LSB]       <= `DEF_RESUME;
      nvb_reg[`NVB_PAUSE_LSB+7:`NVB_PAUSE_LSB]         <= `DEF_PAUSE;
    end else begin
      if (apb_wr && (i_paddr == `OFS_DRAW_MODE)) begin
        draw_mode_reg <= i_pwdata[7:0];
      end
      if (restore_pulse) begin
        nva_reg <= 32'h0000_0000;
        nvb_reg <= 32'h0000_0000;
        nva_reg[`NVA_BAUD_LSB+2:`NVA_BAUD_LSB]           <= `DEF_BAUD_CODE;
        nva_reg[`NVA_SPLASH_LSB+1:`NVA_SPLASH_LSB]       <= `DEF_SPLASH;
        nva_reg[`NVA_LINE_END_BIT]                       <= `DEF_LINE_END;
        nva_reg[`NVA_REVERSE_BIT]                        <= `DEF_REVERSE;
        nva_reg[`NVA_BACKLIGHT_LSB+7:`NVA_BACKLIGHT_LSB] <= `DEF_BACKLIGHT;
        nvb_reg[`NVB_SCROLL_LSB+7:`NVB_SCROLL_LSB]       <= `DEF_SCROLL;
        nvb_reg[`NVB_RESUME_LSB+7:`NVB_RESUME_LSB]       <= `DEF_RESUME;
        nvb_reg[`NVB_PAUSE_LSB+7:`NVB_PAUSE_LSB]         <= `DEF_PAUSE;
        nvb_reg[`NVB_FONT_BIT]                           <= `DEF_FONT;
      end else begin
        if (apb_wr && (i_paddr == `OFS_NV_A)) begin
          nva_reg <= {8'h00, i_pwdata[23:16], 6'h00, i_pwdata[9:8], 2'h0,
                      i_pwdata[5:4], 1'b0, i_pwdata[2:0]};
        end
        if (apb_wr && (i_paddr == `OFS_NV_B)) begin
          nvb_reg <= {7'h00, i_pwdata[24:0]};
        end
        if (font_store) begin
          nvb_reg[`NVB_FONT_BIT] <= par_reg[0][0];
        end
      end
    end
  end

  // Read data captured in the setup phase, stable through the access phase
  always @(posedge i_clk) begin
    if (!i_rst_b) begin
      o_prdata <= 32'h0000_0000;
    end else if (apb_setup && !i_pwrite) begin
      case (i_paddr)
        `OFS_DRAW_MODE: o_prdata <= {24'h00_0000, draw_mode_reg};
        `OFS_STATUS:    o_prdata <= {16'h0000, text_mode_reg, 3'h0, font_reg,
                                     (state_reg == ST_ECHO), (state_reg == ST_DRAW),
                                     (state_reg != ST_IDLE), batch_reg};
        `OFS_NV_A:      o_prdata <= nva_reg;
        `OFS_NV_B:      o_prdata <= nvb_reg;
        default:        o_prdata <= 32'h0000_0000;
      endcase
    end
  end

endmodule

/* File: lcd_cmd_parser_chk_asserts.sv */
// Port-level checks of the serial display command parser
module lcd_cmd_parser_chk (
  input wire       i_clk,
  input wire       i_rst_b,
  input wire       i_psel,
  input wire       i_penable,
  input wire [7:0] i_paddr,
  input wire       o_pready,
  input wire       o_pslverr,
  input wire       o_rx_ready,
  input wire       o_draw_valid,
  input wire [1:0] o_draw_op,
  input wire [7:0] o_draw_x1,
  input wire [7:0] o_draw_y1,
  input wire [7:0] o_draw_x2,
  input wire [7:0] o_draw_y2,
  input wire [7:0] o_draw_data,
  input wire       i_draw_ready,
  input wire       i_draw_busy,
  input wire       o_tx_valid,
  input wire [7:0] o_tx_data,
  input wire       i_tx_ready,
  input wire [7:0] o_text_mode,
  input wire       o_text_prop
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking dc @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  // Handshake steps of the renderer and echo paths
  sequence s_draw_stall; o_draw_valid && !i_draw_ready; endsequence
  sequence s_draw_take; o_draw_valid && i_draw_ready; endsequence
  sequence s_tx_stall; o_tx_valid && !i_tx_ready; endsequence
  // Zero-wait slave, error on holes in the map and on offsets above 0x0C
  a_pready_high: assert property (o_pready) else $error("pready low");
  a_unmapped_err: assert property (i_psel && i_penable |->
    o_pslverr == (i_paddr[1:0] != 2'h0 || i_paddr > 8'h0C)) else $error("bad pslverr");
  a_rect_sorted: assert property (o_draw_valid && o_draw_op != 2'h0 |->
    o_draw_x1 <= o_draw_x2 && o_draw_y1 <= o_draw_y2) else $error("corners unsorted");
  a_erase_colour: assert property (o_draw_valid && o_draw_op == 2'h1 |->
    o_draw_data == 8'h00 || o_draw_data == 8'hFF) else $error("erase colour");
  a_draw_hold: assert property (s_draw_stall |=> o_draw_valid && $stable({o_draw_op,
    o_draw_x1, o_draw_y1, o_draw_x2, o_draw_y2, o_draw_data})) else $error("draw dropped");
  a_handoff_free: assert property (s_draw_take |=> !o_draw_valid && o_rx_ready)
    else $error("stream not freed");
  a_rx_blocked: assert property (o_draw_valid || o_tx_valid |-> !o_rx_ready)
    else $error("byte taken while busy");
  a_tx_hold: assert property (s_tx_stall |=> o_tx_valid && $stable(o_tx_data))
    else $error("echo dropped");
  a_echo_waits: assert property (o_tx_valid |-> !i_draw_busy)
    else $error("echo before drawing done");
  a_prop_flag: assert property ($changed(o_text_prop) && $past(i_rst_b) |->
    !$past(o_rx_ready)) else $error("prop flag changed outside a command");
endmodule

/* File: host_model.sv */
// Behavioural host: feeds the command stream and collects echoed bytes
module host_model (
  input  wire logic       i_clk,
  input  wire logic       i_rx_ready,
  input  wire logic       i_tx_valid,
  input  wire logic [7:0] i_tx_data,
  input  wire logic       i_slow,
  output logic            o_rx_valid,
  output logic      [7:0] o_rx_data,
  output logic            o_tx_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] send_q[$];
  logic [7:0] echo_q[$];
  initial begin
    o_rx_valid = 1'b0;
    o_rx_data  = 8'h00;
    o_tx_ready = 1'b1;
  end
  always @(posedge i_clk) begin
    if (o_rx_valid && i_rx_ready)
      void'(send_q.pop_front());
    // Idle line inverts so a stale byte never looks valid
    if (send_q.size() > 0) begin
      o_rx_valid <= 1'b1;
      o_rx_data  <= send_q[0];
    end else begin
      o_rx_valid <= 1'b0;
      o_rx_data  <= ~o_rx_data;
    end
    // Slow mode refuses every other echo cycle
    o_tx_ready <= i_slow ? ~o_tx_ready : 1'b1;
    if (i_tx_valid && o_tx_ready)
      echo_q.push_back(i_tx_data);
  end
endmodule

/* File: serial_lcd_command_parser_bench.sv */
// Self-checking bench of the serial display command parser
module serial_lcd_command_parser_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        i_clk = 1'b0, i_rst_b = 1'b0, i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0;
  logic [7:0]  i_paddr = 8'h00, i_rx_data, o_tx_data, o_text_mode, o_draw_data;
  logic [31:0] i_pwdata = 32'h0000_0000, o_prdata, rd;
  logic        o_pready, o_pslverr, i_rx_valid, o_rx_ready, o_draw_valid, o_tx_valid;
  logic        i_draw_ready = 1'b0, i_draw_busy = 1'b0, i_tx_ready, slow = 1'b0, err;
  logic [7:0]  o_draw_x1, o_draw_y1, o_draw_x2, o_draw_y2, a, b, c, d, m;
  logic [1:0]  o_draw_op, o_text_logic, o_draw_logic;
  logic        o_font_sel, o_text_normal, o_text_fill, o_text_prop, o_draw_normal, o_draw_fill;
  logic [41:0] exp_q[$], got;
  integer      seed = 52169, miscompares = 0, tests_run = 0, i;
  initial forever #4 i_clk = ~i_clk;
  lcd_cmd_parser dut (.*);
  host_model host (.i_clk, .i_rx_ready(o_rx_ready), .i_tx_valid(o_tx_valid),
    .i_tx_data(o_tx_data), .i_slow(slow), .o_rx_valid(i_rx_valid), .o_rx_data(i_rx_data),
    .o_tx_ready(i_tx_ready));
  task check(input logic [41:0] seen, input logic [41:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task test_done;
    if (miscompares == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task give_up;
    miscompares++;
    test_done;
  endtask
  // Any byte but the leader, so parameters never reframe
  function logic [7:0] rb;
    rb = $random(seed);
    if (rb == 8'h7C) rb = 8'h7D;
  endfunction
  // Expected rectangle op with sorted inclusive corners
  function logic [41:0] rect(input logic [1:0] op, input logic [7:0] dt);
    rect = {op, a < c ? a : c, b < d ? b : d, a < c ? c : a, b < d ? d : b, dt};
  endfunction
  task apb(input logic wr, input logic [7:0] ad, input logic [31:0] wd);
    integer n;
    @(posedge i_clk);
    i_psel    <= 1'b1;
    i_penable <= 1'b0;
    i_pwrite  <= wr;
    i_paddr   <= ad;
    i_pwdata  <= wd;
    @(posedge i_clk);
    i_penable <= 1'b1;
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
    end while (o_pready !== 1'b1 && n < 50);
    if (o_pready !== 1'b1) give_up;
    rd  = o_prdata;
    err = o_pslverr;
    i_psel    <= 1'b0;
    i_penable <= 1'b0;
  endtask
  task rdchk(input logic [7:0] ad, input logic [31:0] exp);
    apb(1'b0, ad, 32'h0000_0000);
    check({err, rd}, {1'b0, exp});
  endtask
  // Waits until stream, renderer and echo path are all quiet
  task send(input logic [7:0] s[$]);
    integer n;
    @(negedge i_clk);
    foreach (s[k]) host.send_q.push_back(s[k]);
    for (n = 0; n < 400; n++) begin
      @(negedge i_clk);
      if (host.send_q.size() == 0 && exp_q.size() == 0 &&
          {i_rx_valid, o_rx_ready, o_draw_valid, o_tx_valid} === 4'b0100) break;
    end
    if (n == 400) give_up;
    @(negedge i_clk);
  endtask
  // Renderer: random acceptance, busy for a while after each op
  always @(posedge i_clk) begin
    if (o_draw_valid === 1'b1 && i_draw_ready === 1'b1) begin
      got = {o_draw_op, o_draw_x1, o_draw_y1, o_draw_x2, o_draw_y2, o_draw_data};
      if (o_draw_op === 2'h0) got[39:8] = 32'h0000_0000;
      if (exp_q.size() == 0) give_up;
      else check(got, exp_q.pop_front());
    end
    if (o_tx_valid === 1'b1 && i_tx_ready === 1'b1) check(exp_q.size(), 0);
    i_draw_ready <= $random(seed);
    i_draw_busy  <= (o_draw_valid === 1'b1 && i_draw_ready) || (i_draw_busy && ($random(seed) & 3) != 0);
  end
  initial begin
    repeat (4) @(posedge i_clk);
    i_rst_b <= 1'b1;
    rdchk(8'h08, 32'h0064_0016);
    rdchk(8'h0C, 32'h00A6_1400);
    apb(1'b0, 8'h12, 32'h0000_0000);
    check({err, rd}, {1'b1, 32'h0000_0000});
    for (i = 0; i < 6; i++) begin
      m = rb();
      exp_q.push_back({2'h0, 32'h0000_0000, m});
      send({m});
    end
    // Erase in normal then reverse colour, random corner order
    for (i = 0; i < 2; i++) begin
      {a, b, c, d} = {rb(), rb(), rb(), rb()};
      apb(1'b1, 8'h08, {22'h00_0190, i[0], 9'h016});
      exp_q.push_back(rect(2'h1, {8{i[0]}}));
      send({8'h7C, 8'h05, a, b, c, d});
    end
    // Pattern fill with clear, full and random stripes
    for (i = 0; i < 3; i++) begin
      {a, b, c, d} = {rb(), rb(), rb(), rb()};
      m = i == 0 ? 8'h00 : i == 1 ? 8'hFF : rb();
      exp_q.push_back(rect(2'h2, m));
      send({8'h7C, 8'h06, a, b, c, d, m});
    end
    // Every logic code of the draw mode, then a mode fill
    for (i = 0; i < 4; i++) begin
      m = rb();
      m[2:1] = i;
      apb(1'b1, 8'h00, {24'h00_0000, m});
      @(negedge i_clk);
      check({o_draw_fill, o_draw_logic, o_draw_normal}, {m[3], m[2:1], m[0]});
      {a, b, c, d} = {rb(), rb(), rb(), rb()};
      exp_q.push_back(rect(2'h3, m));
      send({8'h7C, 8'h46, a, b, c, d});
    end
    // Echo queued behind a fill while the transmitter stalls
    slow <= 1'b1;
    exp_q.push_back(rect(2'h2, 8'h5A));
    send({8'h7C, 8'h06, a, b, c, d, 8'h5A, 8'h7C, 8'h17, m});
    check(host.echo_q.size(), 1);
    check(host.echo_q.pop_front(), m);
    for (i = 0; i < 2; i++) begin
      m = rb();
      m[5] = i;
      send({8'h7C, 8'h0A, m});
      check({o_text_prop, o_text_fill, o_text_logic, o_text_normal, o_text_mode},
        {m[5], m[3], m[2:1], m[0], m});
    end
    // Temporary font leaves the stored default alone
    send({8'h7C, 8'h48, 8'h01});
    check(o_font_sel, 1'b1);
    rdchk(8'h0C, 32'h00A6_1400);
    send({8'h7C, 8'h08, 8'h01});
    rdchk(8'h0C, 32'h01A6_1400);
    send({8'h7C, 8'h48, 8'h00});
    check(o_font_sel, 1'b0);
    rdchk(8'h0C, 32'h01A6_1400);
    apb(1'b1, 8'h08, $random(seed));
    apb(1'b1, 8'h0C, $random(seed));
    send({8'h7C, 8'h1F});
    rdchk(8'h08, 32'h0064_0016);
    rdchk(8'h0C, 32'h00A6_1400);
    // host restarts the display after restoring
    @(posedge i_clk);
    i_rst_b <= 1'b0;
    repeat (2) @(posedge i_clk);
    i_rst_b <= 1'b1;
    rdchk(8'h00, 32'h0000_0001);
    // batch traffic ends on the exit code, then on a leader-prefixed erase
    for (i = 0; i < 2; i++) begin
      send({8'h7C, 8'h40});
      apb(1'b0, 8'h04, 32'h0000_0000);
      check(rd[0], 1'b1);
      {a, b, c, d} = {rb(), rb(), rb(), rb()};
      exp_q.push_back(rect(2'h1, 8'h00));
      if (i == 0) send({8'h05, a, b, c, d, 8'h41});
      else send({8'h7C, 8'h05, a, b, c, d});
      m = rb();
      exp_q.push_back({2'h0, 32'h0000_0000, m});
      send({m});
      apb(1'b0, 8'h04, 32'h0000_0000);
      check(rd[0], 1'b0);
    end
    test_done;
  end
endmodule
bind lcd_cmd_parser lcd_cmd_parser_chk chk (.i_clk, .i_rst_b, .i_psel, .i_penable, .i_paddr,
  .o_pready, .o_pslverr, .o_rx_ready, .o_draw_valid, .o_draw_op, .o_draw_x1, .o_draw_y1,
  .o_draw_x2, .o_draw_y2, .o_draw_data, .i_draw_ready, .i_draw_busy, .o_tx_valid,
  .o_tx_data, .i_tx_ready, .o_text_mode, .o_text_prop);
